// file: core/t16pwm_consts.svh
/*
  Constants for the dual-slope PWM timer: mode codes, fixed TOP values,
  output-mode codes, prescale divisors and reset values.
  Assumes inclusion by bare name from the package and the modules.
*/
//
// Summary of operation
// - phase correct sets overflow at bottom
// - top-source flag rises at top
// - fixed top masks high compare bits
// - compare above top never matches
// - phase correct loads buffers at top
// - mode 2 non-inverted, mode 3 inverted
// - clear on up match, set on down
// - pin driven only when direction is output
// - prescale by 1, 8, 64, 256, 1024
// - bottom holds low, top holds high
// - mode 0xB with code 1 toggles output A
// - pfc counts bottom to top and back
// - pfc top from capture or compare A
// - phase correct: load top, overflow bottom
// - pfc: load bottom, overflow bottom
// - clear-on-match: immediate load, overflow max
// - fast pwm: load bottom, overflow top
`ifndef T16PWM_CONSTS_SVH
`define T16PWM_CONSTS_SVH

// waveform mode codes
`define T16_WGM_NORMAL 4'h0
`define T16_WGM_PC8 4'h1
`define T16_WGM_PC9 4'h2
`define T16_WGM_PC10 4'h3
`define T16_WGM_CTC_OCR 4'h4
`define T16_WGM_FAST8 4'h5
`define T16_WGM_FAST9 4'h6
`define T16_WGM_FAST10 4'h7
`define T16_WGM_PFC_ICR 4'h8
`define T16_WGM_PFC_OCR 4'h9
`define T16_WGM_PC_ICR 4'hA
`define T16_WGM_PC_OCR 4'hB
`define T16_WGM_CTC_ICR 4'hC
`define T16_WGM_RSVD 4'hD
`define T16_WGM_FAST_ICR 4'hE
`define T16_WGM_FAST_OCR 4'hF

// fixed top values
`define T16_TOP_8 16'h00FF
`define T16_TOP_9 16'h01FF
`define T16_TOP_10 16'h03FF
`define T16_MAX 16'hFFFF
`define T16_BOTTOM 16'h0000

// compare output mode codes
`define T16_COM_OFF 2'h0
`define T16_COM_TOGGLE 2'h1
`define T16_COM_NONINV 2'h2
`define T16_COM_INV 2'h3

// clock select codes and divisors
`define T16_CS_STOP 3'h0
`define T16_CS_DIV1 3'h1
`define T16_CS_DIV8 3'h2
`define T16_CS_DIV64 3'h3
`define T16_CS_DIV256 3'h4
`define T16_CS_DIV1024 3'h5
`define T16_DIV8_LAST 10'h007
`define T16_DIV64_LAST 10'h03F
`define T16_DIV256_LAST 10'h0FF
`define T16_DIV1024_LAST 10'h3FF

// reset values
`define T16_RST_WORD 16'h0000
`define T16_RST_BIT 1'h0
`define T16_RST_OE_N 1'h1

`endif

// file: core/t16pwm_pkg.sv
/*
  Types shared by the timer modules: decoded mode fields, count direction
  and the packed state of the top module.
  Assumes the constants header is on the include path.
*/
package t16pwm_pkg;

  typedef enum logic [1:0] {T16_TSRC_FIXED = 2'h0, T16_TSRC_ICR = 2'h1,
                            T16_TSRC_OCRA = 2'h3} t16pwm_tsrc_t;
  typedef enum logic [1:0] {T16_UPD_IMM = 2'h0, T16_UPD_TOP = 2'h1,
                            T16_UPD_BOT = 2'h3} t16pwm_upd_t;
  typedef enum logic [1:0] {T16_OVF_MAX = 2'h0, T16_OVF_TOP = 2'h1,
                            T16_OVF_BOT = 2'h3} t16pwm_ovf_t;
  typedef enum logic [1:0] {T16_SHAPE_PLAIN = 2'h0, T16_SHAPE_FAST = 2'h1,
                            T16_SHAPE_DUAL = 2'h3} t16pwm_shape_t;
  // direction state machine: one bit, gray by nature
  typedef enum logic {T16_UP = 1'b0, T16_DOWN = 1'b1} t16pwm_dir_t;

  typedef struct packed {
    logic [15:0] cnt;
    t16pwm_dir_t dir;
    logic [15:0] ocr_a;
    logic [15:0] ocr_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] icr;
    logic oc_a;
    logic oc_b;
    logic tov;
    logic ocf_a;
    logic ocf_b;
    logic icf;
    logic pin_a;
    logic pin_oe_n_a;
    logic pin_b;
    logic pin_oe_n_b;
  } t16pwm_state_t;

endpackage : t16pwm_pkg

// file: core/t16pwm_prescale.sv
/*
  Prescaler: turns the I/O clock into a one-cycle timer tick.
  Assumes clk_select comes from logic on clk_sys.
*/
`timescale 1ns/1ns
`include "t16pwm_consts.svh"
module t16pwm_prescale (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] clk_select,
  output logic tick
);

  logic [9:0] div_r;
  logic [9:0] div_nxt;

  ////////////////////////////////////////////////////////////////////////
  // free divider and tap select
  always_comb
  begin
    div_nxt = div_r + 10'h001;
    case (clk_select)
      `T16_CS_DIV1: tick = 1'b1;
      `T16_CS_DIV8: tick = (div_r[2:0] == 3'(`T16_DIV8_LAST));
      `T16_CS_DIV64: tick = (div_r[5:0] == 6'(`T16_DIV64_LAST));
      `T16_CS_DIV256: tick = (div_r[7:0] == 8'(`T16_DIV256_LAST));
      `T16_CS_DIV1024: tick = (div_r == `T16_DIV1024_LAST);
      default: tick = 1'b0; // stopped or unused codes
    endcase
  end

  // shared divider: a select change lands mid-period, as on the real part
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      div_r <= 10'h000;
    else
      div_r <= div_nxt;
  end

  // divide by 64 ticks on the last phase only
  div64_tap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_select == `T16_CS_DIV64 && tick) |-> (div_r[5:0] == 6'h3F))
    else $error("div64 tick off phase");

  div1024_gap_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_select == `T16_CS_DIV1024 && tick) |=> !tick)
    else $error("div1024 ticks back to back");

endmodule : t16pwm_prescale

// file: core/t16pwm_mode_dec.sv
/*
  Waveform mode decoder: splits the four-bit mode into shape, top source,
  fixed top, buffer update point and overflow point.
  Assumes a static mode between reconfigurations.
*/
`timescale 1ns/1ns
`include "t16pwm_consts.svh"
module t16pwm_mode_dec (
  input wire logic [3:0] waveform_mode_select,
  output t16pwm_pkg::t16pwm_shape_t shape,
  output t16pwm_pkg::t16pwm_tsrc_t tsrc,
  output logic [15:0] fixed_top,
  output t16pwm_pkg::t16pwm_upd_t upd,
  output t16pwm_pkg::t16pwm_ovf_t ovf,
  output logic reserved
);

  ////////////////////////////////////////////////////////////////////////
  // table decode
  always_comb
  begin
    shape = t16pwm_pkg::T16_SHAPE_PLAIN;
    tsrc = t16pwm_pkg::T16_TSRC_FIXED;
    fixed_top = `T16_MAX;
    upd = t16pwm_pkg::T16_UPD_IMM;
    ovf = t16pwm_pkg::T16_OVF_MAX;
    reserved = 1'b0;
    case (waveform_mode_select)
      `T16_WGM_PC8, `T16_WGM_PC9, `T16_WGM_PC10, `T16_WGM_PC_ICR, `T16_WGM_PC_OCR:
      begin
        shape = t16pwm_pkg::T16_SHAPE_DUAL;
        upd = t16pwm_pkg::T16_UPD_TOP;
        ovf = t16pwm_pkg::T16_OVF_BOT;
      end
      `T16_WGM_PFC_ICR, `T16_WGM_PFC_OCR:
      begin
        shape = t16pwm_pkg::T16_SHAPE_DUAL;
        upd = t16pwm_pkg::T16_UPD_BOT;
        ovf = t16pwm_pkg::T16_OVF_BOT;
      end
      `T16_WGM_FAST8, `T16_WGM_FAST9, `T16_WGM_FAST10, `T16_WGM_FAST_ICR,
      `T16_WGM_FAST_OCR:
      begin
        shape = t16pwm_pkg::T16_SHAPE_FAST;
        upd = t16pwm_pkg::T16_UPD_BOT;
        ovf = t16pwm_pkg::T16_OVF_TOP;
      end
      `T16_WGM_RSVD: reserved = 1'b1;
      default: ; // normal and clear-on-match keep the defaults
    endcase
    // top source
    case (waveform_mode_select)
      `T16_WGM_PC8, `T16_WGM_FAST8: fixed_top = `T16_TOP_8;
      `T16_WGM_PC9, `T16_WGM_FAST9: fixed_top = `T16_TOP_9;
      `T16_WGM_PC10, `T16_WGM_FAST10: fixed_top = `T16_TOP_10;
      `T16_WGM_CTC_OCR, `T16_WGM_PFC_OCR, `T16_WGM_PC_OCR, `T16_WGM_FAST_OCR:
        tsrc = t16pwm_pkg::T16_TSRC_OCRA;
      `T16_WGM_CTC_ICR, `T16_WGM_PFC_ICR, `T16_WGM_PC_ICR, `T16_WGM_FAST_ICR:
        tsrc = t16pwm_pkg::T16_TSRC_ICR;
      default: ;
    endcase
  end

endmodule : t16pwm_mode_dec

// file: core/t16pwm_top.sv
/*
  Sixteen-bit timer waveform generator: counter, double-buffered compare
  registers A and B, flags and the two compare output pins.
  Assumes all control inputs come from logic on clk_sys; flag clears and
  register writes are one-cycle pulses.
*/
`timescale 1ns/1ns
`include "t16pwm_consts.svh"
module t16pwm_top #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [2:0] clk_select,
  input wire logic [3:0] waveform_mode_select,
  input wire logic [1:0] compare_output_mode_a,
  input wire logic [1:0] compare_output_mode_b,
  input wire logic cmp_a_wr,
  input wire logic [15:0] cmp_a_wdata,
  input wire logic cmp_b_wr,
  input wire logic [15:0] cmp_b_wdata,
  input wire logic capture_top_wr,
  input wire logic [15:0] capture_top_wdata,
  input wire logic pin_direction_bit_a,
  input wire logic pin_direction_bit_b,
  input wire logic overflow_clr,
  input wire logic compare_flag_a_clr,
  input wire logic compare_flag_b_clr,
  input wire logic capture_clr,
  output logic [15:0] timer_count,
  output logic count_down,
  output logic [15:0] compare_value_a,
  output logic [15:0] compare_value_b,
  output logic [15:0] capture_top_value,
  output logic overflow_flag,
  output logic compare_flag_a,
  output logic compare_flag_b,
  output logic capture_flag,
  output logic compare_output_a,
  output logic compare_output_b,
  output logic pin_out_a,
  output logic pin_oe_n_a,
  output logic pin_out_b,
  output logic pin_oe_n_b
);

  // the state record is fixed at sixteen bits wide
  if (CNT_W != 16)
  begin : g_width_check
    $error("t16pwm_top serves a 16-bit counter only");
  end

  t16pwm_pkg::t16pwm_state_t st_r;
  t16pwm_pkg::t16pwm_state_t st_nxt;
  t16pwm_pkg::t16pwm_shape_t shape;
  t16pwm_pkg::t16pwm_tsrc_t tsrc;
  t16pwm_pkg::t16pwm_upd_t upd;
  t16pwm_pkg::t16pwm_ovf_t ovf;
  logic [15:0] fixed_top;
  logic reserved;
  logic tick;
  logic run;
  logic [15:0] top_val;
  logic [15:0] wmask;
  logic at_top;
  logic at_bot;
  logic at_max;
  logic match_up;
  logic match_a;
  logic match_b;
  logic load_buf;
  logic ovf_set;

  ////////////////////////////////////////////////////////////////////////
  // submodules

  t16pwm_prescale u_prescale (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_select(clk_select),
    .tick(tick)
  );

  t16pwm_mode_dec u_mode_dec (
    .waveform_mode_select(waveform_mode_select),
    .shape(shape),
    .tsrc(tsrc),
    .fixed_top(fixed_top),
    .upd(upd),
    .ovf(ovf),
    .reserved(reserved)
  );

  ////////////////////////////////////////////////////////////////////////
  // output action for one compare channel
  function automatic logic wave_next(
    input logic oc,
    input logic [1:0] com,
    input t16pwm_pkg::t16pwm_shape_t shp,
    input logic match,
    input logic up,
    input logic bot,
    input logic tog_ok
  );
    logic res;
    res = oc;
    case (shp)
      t16pwm_pkg::T16_SHAPE_DUAL:
      begin
        // clear going up, set going down; inverted is the mirror
        if (match && com == `T16_COM_NONINV)
          res = !up;
        else if (match && com == `T16_COM_INV)
          res = up;
        // toggle only where compare A is top
        else if (match && com == `T16_COM_TOGGLE && tog_ok)
          res = !oc;
      end
      t16pwm_pkg::T16_SHAPE_FAST:
      begin
        if (match && com == `T16_COM_NONINV)
          res = 1'b0;
        else if (match && com == `T16_COM_INV)
          res = 1'b1;
        else if (match && com == `T16_COM_TOGGLE && tog_ok)
          res = !oc;
        else if (bot && com == `T16_COM_NONINV)
          res = 1'b1;
        else if (bot && com == `T16_COM_INV)
          res = 1'b0;
      end
      default:
      begin
        // plain counting: toggle, clear or set on match
        if (match && com == `T16_COM_TOGGLE)
          res = !oc;
        else if (match && com == `T16_COM_NONINV)
          res = 1'b0;
        else if (match && com == `T16_COM_INV)
          res = 1'b1;
      end
    endcase
    return res;
  endfunction : wave_next

  ////////////////////////////////////////////////////////////////////////
  // event decode from the current state
  always_comb
  begin
    case (tsrc)
      t16pwm_pkg::T16_TSRC_ICR: top_val = st_r.icr;
      t16pwm_pkg::T16_TSRC_OCRA: top_val = st_r.ocr_a;
      default: top_val = fixed_top;
    endcase
    run = tick && !reserved;
    at_top = (st_r.cnt == top_val);
    at_bot = (st_r.cnt == `T16_BOTTOM);
    at_max = (st_r.cnt == `T16_MAX);
    // fixed top clears bits above the resolution
    wmask = (tsrc == t16pwm_pkg::T16_TSRC_FIXED) ? fixed_top : `T16_MAX;
    // bottom counts as rising, top as falling, for the extremes
    match_up = at_bot || (st_r.dir == t16pwm_pkg::T16_UP && !at_top);
    // a compare value above top is never matched
    match_a = run && (st_r.cnt == st_r.ocr_a) && (st_r.ocr_a <= top_val);
    match_b = run && (st_r.cnt == st_r.ocr_b) && (st_r.ocr_b <= top_val);
    load_buf = run && ((upd == t16pwm_pkg::T16_UPD_TOP && at_top) ||
                       (upd == t16pwm_pkg::T16_UPD_BOT && at_bot));
    case (ovf)
      t16pwm_pkg::T16_OVF_BOT: ovf_set = run && at_bot;
      t16pwm_pkg::T16_OVF_TOP: ovf_set = run && at_top;
      default: ovf_set = run && at_max;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt = st_r;
    // counter and direction
    if (run)
    begin
      if (shape == t16pwm_pkg::T16_SHAPE_DUAL)
      begin
        // up to top, one tick at top, then down to bottom
        if (st_r.dir == t16pwm_pkg::T16_UP)
        begin
          if (st_r.cnt >= top_val && !at_bot)
          begin
            st_nxt.dir = t16pwm_pkg::T16_DOWN;
            st_nxt.cnt = st_r.cnt - 16'h0001;
          end
          else
            st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        else if (at_bot)
        begin
          st_nxt.dir = t16pwm_pkg::T16_UP;
          st_nxt.cnt = st_r.cnt + 16'h0001;
        end
        else
          st_nxt.cnt = st_r.cnt - 16'h0001;
      end
      else
      begin
        // single slope wraps at top; a top below count runs on through max
        st_nxt.dir = t16pwm_pkg::T16_UP;
        st_nxt.cnt = at_top ? `T16_BOTTOM : st_r.cnt + 16'h0001;
      end
    end
    // buffered values go live at the update point
    if (load_buf)
    begin
      st_nxt.ocr_a = st_r.buf_a;
      st_nxt.ocr_b = st_r.buf_b;
    end
    // writes land in the buffer, live at once when immediate
    if (cmp_a_wr)
    begin
      st_nxt.buf_a = cmp_a_wdata & wmask;
      if (upd == t16pwm_pkg::T16_UPD_IMM)
        st_nxt.ocr_a = cmp_a_wdata & wmask;
    end
    if (cmp_b_wr)
    begin
      st_nxt.buf_b = cmp_b_wdata & wmask;
      if (upd == t16pwm_pkg::T16_UPD_IMM)
        st_nxt.ocr_b = cmp_b_wdata & wmask;
    end
    if (capture_top_wr)
      st_nxt.icr = capture_top_wdata;
    // flags: a set in the clearing cycle wins
    st_nxt.tov = ovf_set || (st_r.tov && !overflow_clr);
    // compare A match coincides with the load at top when A is top in phase correct
    st_nxt.ocf_a = match_a || (st_r.ocf_a && !compare_flag_a_clr);
    st_nxt.ocf_b = match_b || (st_r.ocf_b && !compare_flag_b_clr);
    // capture flag rises at top when the capture value is top
    st_nxt.icf = (run && at_top && tsrc == t16pwm_pkg::T16_TSRC_ICR) ||
                 (st_r.icf && !capture_clr);
    // waveform outputs
    st_nxt.oc_a = wave_next(st_r.oc_a, compare_output_mode_a, shape, match_a,
                            match_up, run && at_bot,
                            tsrc == t16pwm_pkg::T16_TSRC_OCRA);
    st_nxt.oc_b = wave_next(st_r.oc_b, compare_output_mode_b, shape, match_b,
                            match_up, run && at_bot, 1'b0);
    // the pin is driven only when direction says output
    st_nxt.pin_a = st_nxt.oc_a;
    st_nxt.pin_oe_n_a = !(pin_direction_bit_a && compare_output_mode_a != `T16_COM_OFF);
    st_nxt.pin_b = st_nxt.oc_b;
    st_nxt.pin_oe_n_b = !(pin_direction_bit_b && compare_output_mode_b != `T16_COM_OFF);
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      st_r <= '0;
      st_r.pin_oe_n_a <= `T16_RST_OE_N;
      st_r.pin_oe_n_b <= `T16_RST_OE_N;
    end
    else
      st_r <= st_nxt;
  end

  // every output straight from the state record
  assign timer_count = st_r.cnt;
  assign count_down = st_r.dir;
  assign compare_value_a = st_r.ocr_a;
  assign compare_value_b = st_r.ocr_b;
  assign capture_top_value = st_r.icr;
  assign overflow_flag = st_r.tov;
  assign compare_flag_a = st_r.ocf_a;
  assign compare_flag_b = st_r.ocf_b;
  assign capture_flag = st_r.icf;
  assign compare_output_a = st_r.oc_a;
  assign compare_output_b = st_r.oc_b;
  assign pin_out_a = st_r.pin_a;
  assign pin_oe_n_a = st_r.pin_oe_n_a;
  assign pin_out_b = st_r.pin_b;
  assign pin_oe_n_b = st_r.pin_oe_n_b;

  ////////////////////////////////////////////////////////////////////////
  // checks

  bottom_ovf_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tick && !reserved && shape == t16pwm_pkg::T16_SHAPE_DUAL &&
     timer_count == 16'h0000) |=> overflow_flag)
    else $error("dual slope bottom left overflow clear");

  icr_top_a: assert property (@(posedge clk_sys) disable iff (rst)
    (tick && tsrc == t16pwm_pkg::T16_TSRC_ICR && !reserved &&
     timer_count == capture_top_value) |=> capture_flag)
    else $error("capture flag missing at top");

  mask_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cmp_b_wr && tsrc == t16pwm_pkg::T16_TSRC_FIXED)
    |=> ((st_r.buf_b & ~$past(fixed_top)) == 16'h0000))
    else $error("compare write kept bits above resolution");

  above_top_a: assert property (@(posedge clk_sys) disable iff (rst)
    (run && timer_count == compare_value_b && compare_value_b > top_val &&
     !compare_flag_b) |=> !compare_flag_b)
    else $error("compare flag set with value above top");

  pc_load_a: assert property (@(posedge clk_sys) disable iff (rst)
    (upd == t16pwm_pkg::T16_UPD_TOP && run && at_top && !cmp_b_wr)
    |=> (compare_value_b == $past(st_r.buf_b)))
    else $error("phase correct buffer not loaded at top");

  nonin_up_a: assert property (@(posedge clk_sys) disable iff (rst)
    (match_a && match_up && shape == t16pwm_pkg::T16_SHAPE_DUAL &&
     compare_output_mode_a == `T16_COM_NONINV) |=> !compare_output_a ##0 !pin_out_a)
    else $error("non-inverted output not cleared on rising match");

  inv_down_a: assert property (@(posedge clk_sys) disable iff (rst)
    (match_b && !match_up && shape == t16pwm_pkg::T16_SHAPE_DUAL &&
     compare_output_mode_b == `T16_COM_INV) |=> !compare_output_b)
    else $error("inverted output not cleared on falling match");

  pin_dir_a: assert property (@(posedge clk_sys) disable iff (rst)
    !pin_direction_bit_a |=> pin_oe_n_a)
    else $error("pin driven while direction is input");

  top_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (run && shape == t16pwm_pkg::T16_SHAPE_DUAL && at_top && !at_bot &&
     !count_down) |=> (count_down && timer_count == $past(timer_count) - 16'h0001))
    else $error("dual slope did not reverse after top");

  pfc_ovf_a: assert property (@(posedge clk_sys) disable iff (rst)
    (run && ovf == t16pwm_pkg::T16_OVF_BOT && upd == t16pwm_pkg::T16_UPD_BOT && at_bot &&
     !cmp_a_wr)
    |=> (compare_value_a == $past(st_r.buf_a)) ##0 overflow_flag)
    else $error("bottom load or overflow missing");

endmodule : t16pwm_top

// file: tb/t16pwm_pin_model.sv
/*
  port pin stage: resolves a compare pin from its data and enable.
  assumes an active-low enable and a pin with no pull.
*/
`timescale 1ns/1ns
module t16pwm_pin_model (
  input wire logic clk_sys,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_level
);
  logic last_r = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  // driven only when enabled
  always_ff @(posedge clk_sys)
  begin
    if (!pin_oe_n)
    begin
      last_r <= pin_out;
    end
  end
  // floating pin shows the inverse so a stale level never passes
  assign pin_level = pin_oe_n ? ~last_r : pin_out;
endmodule : t16pwm_pin_model

// file: tb/timer16_dual_slope_pwm_tb.sv
/*
  bench: dual-slope walk, flags, waveforms, pins, masking, prescale, freeze.
  assumes the tick follows clk_select within a few cycles.
*/
`timescale 1ns/1ns
module timer16_dual_slope_pwm_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sel = 3'h0;
  logic [3:0] mode = 4'h4;
  logic [1:0] coma = 2'h0;
  logic [1:0] comb = 2'h0;
  logic awr = 1'b0;
  logic bwr = 1'b0;
  logic iwr = 1'b0;
  logic [15:0] awd = 16'h0000;
  logic [15:0] bwd = 16'h0000;
  logic [15:0] iwd = 16'h0000;
  logic da = 1'b0;
  logic db = 1'b0;
  logic clr = 1'b0;
  logic [15:0] cnt, cva, cvb, ctv;
  logic dn, ovf, fa, fb, fi, oa, ob, pa, pna, pb, pnb, lvl;
  logic [15:0] lf_r = 16'hEF6A;
  logic [15:0] dv [1:5] = '{16'h0001, 16'h0008, 16'h0040, 16'h0100, 16'h0400};
  int failures = 0;
  int tests_run = 0;
  ////////////////////////////////////////////////////////////////////////
  // clock and design
  always #50 clk_sys = ~clk_sys;
  t16pwm_top uut (.clk_sys(clk_sys), .rst(rst), .clk_select(sel),
    .waveform_mode_select(mode), .compare_output_mode_a(coma), .compare_output_mode_b(comb),
    .cmp_a_wr(awr), .cmp_a_wdata(awd), .cmp_b_wr(bwr), .cmp_b_wdata(bwd),
    .capture_top_wr(iwr), .capture_top_wdata(iwd), .pin_direction_bit_a(da),
    .pin_direction_bit_b(db), .overflow_clr(clr), .compare_flag_a_clr(clr),
    .compare_flag_b_clr(clr), .capture_clr(clr), .timer_count(cnt), .count_down(dn),
    .compare_value_a(cva), .compare_value_b(cvb), .capture_top_value(ctv),
    .overflow_flag(ovf), .compare_flag_a(fa), .compare_flag_b(fb), .capture_flag(fi),
    .compare_output_a(oa), .compare_output_b(ob), .pin_out_a(pa), .pin_oe_n_a(pna),
    .pin_out_b(pb), .pin_oe_n_b(pnb));
  t16pwm_pin_model pin_b (.clk_sys(clk_sys), .pin_out(pb), .pin_oe_n(pnb), .pin_level(lvl));
  ////////////////////////////////////////////////////////////////////////
  // random source and expectations
  function automatic logic [15:0] lf();
    lf_r = {lf_r[14:0], lf_r[15] ^ lf_r[13] ^ lf_r[12] ^ lf_r[10]};
    return lf_r;
  endfunction : lf
  // level after a match; rise says the match counts as up-going
  function automatic logic wave(input logic cur, input logic [1:0] com, input logic rise);
    if (com == 2'h1)
      return ~cur;
    return (com == 2'h3) ? rise : ~rise;
  endfunction : wave
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // drivers, all on the falling edge
  task automatic do_rst();
    rst = 1'b1;
    sel = 3'h0;
    mode = 4'h4;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
  endtask : do_rst
  // mode 4 writes land in the live registers too
  task automatic wr(input logic [15:0] a, input logic [15:0] b, input logic [15:0] i);
    awd = a;
    bwd = b;
    iwd = i;
    {awr, bwr, iwr} = 3'h7;
    @(negedge clk_sys);
    {awr, bwr, iwr} = 3'h0;
  endtask : wr
  // bounded wait for the counter to move; a hang ends the run
  task automatic tick_wait(input int lim, output int n);
    logic [15:0] t;
    t = cnt;
    n = 0;
    while (cnt === t && n < lim)
    begin
      @(negedge clk_sys);
      n++;
    end
    if (n >= lim)
    begin
      failures++;
      summarize();
    end
  endtask : tick_wait
  // a used-up bound is a mismatch and ends the run
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      failures++;
      summarize();
    end
  endtask : bound
  ////////////////////////////////////////////////////////////////////////
  // dual-slope run against a cycle model; clears pulsed at random to exercise sticky flags
  task automatic run_dual(input logic [3:0] m, input int k);
    logic [15:0] top, vb, c, r;
    logic up, ea, eb, fov, ffa, ffb, so, sa, sb, si;
    int n;
    do_rst();
    top = 16'h0004 + (lf() & 16'h000F);
    vb = (k == 0) ? 16'h0000 : (k == 1) ? top : lf() % (top + 16'h0003);
    coma = m[0] ? 2'h1 : 2'h2;
    comb = lf_r[0] ? 2'h3 : 2'h2;
    da = lf_r[1];
    db = lf_r[2];
    wr(top, vb, top);
    mode = m;
    clr = 1'b1;
    sel = 3'h1;
    {c, up, ea, eb, so, sa, sb, si} = {16'h0000, 7'h40};
    tick_wait(8, n);
    repeat (4 * top + 4)
    begin
      fov = (c == 16'h0000);
      ffa = (c == top);
      ffb = (c == vb) && (vb <= top);
      // sticky flags; an event in the clearing cycle wins
      so = fov || (so && !clr);
      sa = ffa || (sa && !clr);
      sb = ffb || (sb && !clr);
      si = (ffa && !m[0]) || (si && !clr);
      if (ffa)
        ea = wave(ea, coma, 1'b0);
      if (ffb)
        eb = wave(eb, comb, fov || (!ffa && up));
      c = up ? (ffa ? top - 16'h0001 : c + 16'h0001) : (fov ? 16'h0001 : c - 16'h0001);
      up = up ? !ffa : fov;
      chk("count", c, cnt); // walk
      chk("down", 16'(!up), 16'(dn)); // reversal
      chk("overflow", 16'(so), 16'(ovf)); // bottom
      chk("flag_a", 16'(sa), 16'(fa)); // top flag
      chk("capture", 16'(si), 16'(fi)); // top flag
      chk("flag_b", 16'(sb), 16'(fb)); // B match
      chk("out_a", 16'(ea), 16'(oa)); // levels
      chk("out_b", 16'(eb), 16'(ob)); // levels
      chk("pin_a", 16'(ea), 16'(pa)); // pin data
      chk("oe_a", 16'(!da), 16'(pna)); // direction
      chk("oe_b", 16'(!db), 16'(pnb)); // direction
      if (db)
        chk("pin_b", 16'(eb), 16'(lvl)); // pin level
      r = lf();
      clr = r[0];
      @(negedge clk_sys);
    end
  endtask : run_dual
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    int n;
    logic [15:0] t;
    for (int i = 0; i < 12; i++)
      run_dual(4'h8 + 4'(i % 4), i / 4);
    do_rst();
    mode = 4'h0;
    for (int s = 1; s <= 5; s++)
    begin
      sel = 3'(s);
      tick_wait(2100, n);
      tick_wait(2100, n);
      chk("prescale", dv[s], 16'(n)); // divisor
    end
    // fixed tops: full-scale writes come back masked, loaded at top
    for (int m = 1; m <= 3; m++)
    begin
      do_rst();
      mode = 4'(m);
      wr(16'hFFFF, 16'hFFFF, 16'h0000);
      sel = 3'h1;
      t = (16'h0080 << m) - 16'h0001;
      n = 0;
      while (cvb === 16'h0000 && n < 1100)
      begin
        @(negedge clk_sys);
        n++;
      end
      bound(n, 1100);
      chk("mask_b", t, cvb); // masking
      chk("mask_a", t, cva); // masking
      chk("load_point", t - 16'h0001, cnt); // top load
    end
    // fast 8-bit: buffers load at bottom, overflow at top
    do_rst();
    mode = 4'h5;
    clr = 1'b0;
    wr(16'h0010, 16'hFFFF, 16'h0000);
    sel = 3'h1;
    n = 0;
    while (ovf !== 1'b1 && n < 300)
    begin
      @(negedge clk_sys);
      n++;
    end
    bound(n, 300);
    chk("fast_wrap", 16'h0000, cnt); // overflow at top
    chk("fast_load", 16'h0010, cva); // bottom load
    chk("fast_mask", 16'h00FF, cvb); // masking
    mode = 4'hD;
    repeat (2) @(negedge clk_sys);
    t = cnt;
    repeat (20) @(negedge clk_sys);
    chk("frozen", t, cnt); // reserved
    summarize();
  end
endmodule : timer16_dual_slope_pwm_tb
